// [rtl/pfdr_fault_unit.sv]
/*
  pfdr_fault_unit: translation_fault_exception detect and report unit.
  Watches each translation step, builds the error code, latches the
  fault_address_register and hands the restart point to the core.
  Assumes the walker and core context are synchronous to clk_in and
  that software reaches the control bits over AXI4-Lite.
*/
`timescale 1ns/1ns

module pfdr_fault_unit
  import pfdr_pkg::*;
#(
  parameter int unsigned LA_W = 32 // linear address width
) (
  input wire logic clk_in,                   // core clock
  input wire logic rstn_in,                  // sync reset, active low
  input wire logic walk_valid_in,            // one step offered
  input wire pfdr_walk_s walk_in,            // step contents
  input wire pfdr_ctx_s ctx_in,              // restart context
  input wire logic awvalid,                  // axi write address
  output logic awready,                      // axi
  input wire logic [31:0] awaddr,            // axi
  input wire logic wvalid,                   // axi write data
  output logic wready,                       // axi
  input wire logic [31:0] wdata,             // axi
  input wire logic [3:0] wstrb,              // axi
  output logic bvalid,                       // axi write response
  input wire logic bready,                   // axi
  output logic [1:0] bresp,                  // axi
  input wire logic arvalid,                  // axi read address
  output logic arready,                      // axi
  input wire logic [31:0] araddr,            // axi
  output logic rvalid,                       // axi read data
  input wire logic rready,                   // axi
  output logic [31:0] rdata,                 // axi
  output logic [1:0] rresp,                  // axi
  output logic fault_out,                    // fault raised, pulse
  output logic [31:0] fault_addr_out,        // fault_address_register
  output logic [31:0] push_data_out,         // error code to push
  output logic [31:0] push_addr_out,         // stack slot for push
  output logic [31:0] saved_ip_out,          // restart pointer
  output logic own_stack_out,                // handler stack in use
  output logic sp_inconsistent_out,          // stale pointer in use
  output logic load_full_state_out,          // load new task wholesale
  output logic accessed_set_out,             // set accessed flag
  output logic write_block_out               // squash memory write
);

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  if (LA_W != 32) begin : g_bad_width
    $error("pfdr_fault_unit: only 32-bit linear addresses supported");
  end

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [31:0] addr);
    // bit 2 flags a hit, low bits give the register
    unique case (addr[7:0])
      PFDR_CTRL_OFS: reg_sel = 3'h4;
      PFDR_FADDR_OFS: reg_sel = 3'h5;
      PFDR_ECODE_OFS: reg_sel = 3'h6;
      PFDR_COUNT_OFS: reg_sel = 3'h7;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = m;
  endfunction

  logic [PFDR_CTRL_W-1:0] ctrl;
  logic [31:0] ecode;
  logic [31:0] count;
  wire high_addr_ok = (awaddr[31:8] == 24'h00_0000);
  wire [2:0] wsel = high_addr_ok ? reg_sel(awaddr) : 3'h0;
  wire [2:0] rsel = (araddr[31:8] == 24'h00_0000) ? reg_sel(araddr) : 3'h0;
  wire wr_take = awvalid && wvalid && !awready && !bvalid;
  wire rd_take = arvalid && !arready && !rvalid;
  wire wr_ctrl = wr_take && (wsel == 3'h4);
  wire wr_faddr = wr_take && (wsel == 3'h5);
  wire [31:0] ctrl_word = {27'h000_0000, ctrl};
  // merged in a named wire: a function result cannot be part-selected
  wire [31:0] ctrl_merged = merge(ctrl_word, wdata, wstrb);

  // ----------------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------------
  logic hit;
  logic [31:0] hit_code;

  pfdr_classify u_classify (
    .walk_in(walk_in),
    .ctrl_in(ctrl),
    .fault_out(hit),
    .ecode_out(hit_code)
  );

  wire take = walk_valid_in && hit;
  // own stack when the handler is a task or more privileged
  wire own_stack = ctx_in.handler_task || ctx_in.handler_more_priv;
  // same level and task falls back to the current, maybe stale, pointer
  wire [31:0] stack_top = own_stack ? ctx_in.handler_sp
    : ctx_in.cur_sp;
  wire [31:0] next_push_addr = stack_top - PFDR_PUSH_BYTES;
  // new task table faults restart at the new task's entry point
  wire [31:0] next_saved_ip = ctx_in.new_task_ctx ? ctx_in.new_task_ip
    : ctx_in.cur_ip;
  wire next_accessed = take && walk_in.present;
  wire next_block = take && walk_in.is_write;

  // ----------------------------------------------------------------------
  // fault report registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      fault_out <= 1'b0;
      push_data_out <= PFDR_WORD_RST;
      push_addr_out <= PFDR_WORD_RST;
      saved_ip_out <= PFDR_WORD_RST;
      own_stack_out <= 1'b0;
      sp_inconsistent_out <= 1'b0;
      load_full_state_out <= 1'b0;
      accessed_set_out <= 1'b0;
      write_block_out <= 1'b0;
    end else begin
      fault_out <= take;
      accessed_set_out <= next_accessed;
      write_block_out <= next_block;
      load_full_state_out <= take && ctx_in.in_task_switch;
      if (take) begin
        push_data_out <= hit_code;
        push_addr_out <= next_push_addr;
        saved_ip_out <= next_saved_ip;
        own_stack_out <= own_stack;
        sp_inconsistent_out <= ctx_in.sp_pending && !own_stack;
      end
    end
  end

  // hardware capture beats a software write in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      fault_addr_out <= PFDR_WORD_RST;
      ecode <= PFDR_WORD_RST;
      count <= PFDR_WORD_RST;
    end else if (take) begin
      fault_addr_out <= walk_in.linear_addr;
      ecode <= hit_code;
      count <= count + 32'h0000_0001;
    end else if (wr_faddr) begin
      fault_addr_out <= merge(fault_addr_out, wdata, wstrb);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave: write and read paths, one transfer each at a time
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= PFDR_RESP_OKAY;
      ctrl <= PFDR_CTRL_RST;
    end else begin
      awready <= wr_take;
      wready <= wr_take;
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= wsel[2] ? PFDR_RESP_OKAY : PFDR_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= ctrl_merged[PFDR_CTRL_W-1:0];
      end
    end
  end

  // read data is captured at acceptance so it cannot shift under rvalid
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= PFDR_WORD_RST;
      rresp <= PFDR_RESP_OKAY;
    end else begin
      arready <= rd_take;
      if (rd_take) begin
        rvalid <= 1'b1;
        rresp <= rsel[2] ? PFDR_RESP_OKAY : PFDR_RESP_SLVERR;
        unique case (rsel)
          3'h4: rdata <= ctrl_word;
          3'h5: rdata <= fault_addr_out;
          3'h6: rdata <= ecode;
          3'h7: rdata <= count;
          default: rdata <= PFDR_WORD_RST;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  wire pg_on = ctrl[PFDR_CTRL_PG];

  property p_not_present;
    @(posedge clk_in) disable iff (!rstn_in)
    walk_valid_in && pg_on && !walk_in.present
      |=> fault_out && !push_data_out[PFDR_EC_P];
  endproperty
  a_not_present: assert property (p_not_present)
    else $error("absent page did not fault with P clear");

  property p_user_super;
    @(posedge clk_in) disable iff (!rstn_in)
    walk_valid_in && pg_on && walk_in.present && walk_in.user_mode
      && !walk_in.user_page
      |=> fault_out && push_data_out[PFDR_EC_P] && push_data_out[PFDR_EC_US];
  endproperty
  a_user_super: assert property (p_user_super)
    else $error("user access to supervisor page not reported");

  property p_user_ro;
    @(posedge clk_in) disable iff (!rstn_in)
    walk_valid_in && pg_on && walk_in.user_mode && walk_in.is_write
      && !walk_in.writable |=> fault_out && push_data_out[PFDR_EC_WR];
  endproperty
  a_user_ro: assert property (p_user_ro)
    else $error("user write to read-only page not reported");

  property p_wp;
    @(posedge clk_in) disable iff (!rstn_in)
    walk_valid_in && pg_on && walk_in.present && !walk_in.reserved_violation_bit_set
      && !walk_in.user_mode && walk_in.is_write && !walk_in.writable
      && walk_in.user_page && !walk_in.is_fetch
      |=> fault_out == $past(ctrl[PFDR_CTRL_WP]);
  endproperty
  a_wp: assert property (p_wp)
    else $error("supervisor write fault disagrees with write protect");

  property p_no_fault_off;
    @(posedge clk_in) disable iff (!rstn_in)
    !pg_on || !walk_valid_in |=> !fault_out;
  endproperty
  a_no_fault_off: assert property (p_no_fault_off)
    else $error("fault raised without paging or a walk");

  property p_reserved_violation_bit;
    @(posedge clk_in) disable iff (!rstn_in)
    walk_valid_in && pg_on && walk_in.present && walk_in.reserved_violation_bit_set
      |=> fault_out && push_data_out[PFDR_EC_RESERVED_VIOLATION_BIT]
        == ($past(ctrl[PFDR_CTRL_PSE]) || $past(ctrl[PFDR_CTRL_PAE]));
  endproperty
  a_reserved_violation_bit: assert property (p_reserved_violation_bit)
    else $error("reserved bit fault or its code bit wrong");

  property p_fetch;
    @(posedge clk_in) disable iff (!rstn_in)
    walk_valid_in && pg_on && walk_in.is_fetch && walk_in.exec_disable
      && ctrl[PFDR_CTRL_NXE] |=> fault_out && push_data_out[PFDR_EC_ID];
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch from execute-disabled page not reported");

  property p_addr;
    @(posedge clk_in) disable iff (!rstn_in)
    take |=> fault_addr_out == $past(walk_in.linear_addr);
  endproperty
  a_addr: assert property (p_addr)
    else $error("fault address register missed the faulting address");

  property p_restart;
    @(posedge clk_in) disable iff (!rstn_in)
    take |=> saved_ip_out == ($past(ctx_in.new_task_ctx)
      ? $past(ctx_in.new_task_ip) : $past(ctx_in.cur_ip));
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pointer wrong");

  property p_stack;
    @(posedge clk_in) disable iff (!rstn_in)
    take && !ctx_in.handler_task && !ctx_in.handler_more_priv
      |=> !own_stack_out && push_addr_out == $past(ctx_in.cur_sp) - 32'h4;
  endproperty
  a_stack: assert property (p_stack)
    else $error("push slot not on current stack");

  property p_block;
    @(posedge clk_in) disable iff (!rstn_in)
    take && walk_in.is_write |=> write_block_out && fault_out;
  endproperty
  a_block: assert property (p_block)
    else $error("faulting write not blocked");

  property p_full;
    @(posedge clk_in) disable iff (!rstn_in)
    take |=> load_full_state_out == $past(ctx_in.in_task_switch);
  endproperty
  a_full: assert property (p_full)
    else $error("task switch fault did not load full state");

  property p_accessed;
    @(posedge clk_in) disable iff (!rstn_in)
    take |=> accessed_set_out == $past(walk_in.present);
  endproperty
  a_accessed: assert property (p_accessed)
    else $error("accessed flag update disagrees with entry presence");

  c_absent: cover property (@(posedge clk_in) take && !walk_in.present);
  c_switch: cover property (@(posedge clk_in) take && ctx_in.new_task_ctx);
  c_stale: cover property (@(posedge clk_in) take && ctx_in.sp_pending);
  c_back: cover property (@(posedge clk_in) take ##1 take);

endmodule // pfdr_fault_unit

// [include/pfdr_pkg.sv]
/*
  pfdr_pkg: constants, register map and carrier structs shared by the
  translation fault detect and report block.
  Assumes a 32-bit linear address space and a 32-bit register bus.
*/
package pfdr_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PFDR_CTRL_OFS = 8'h00;
  localparam logic [7:0] PFDR_FADDR_OFS = 8'h04;
  localparam logic [7:0] PFDR_ECODE_OFS = 8'h08;
  localparam logic [7:0] PFDR_COUNT_OFS = 8'h0C;

  // control register fields
  localparam int unsigned PFDR_CTRL_PG = 0;  // paging_enable_flag
  localparam int unsigned PFDR_CTRL_WP = 1;  // supervisor write protect
  localparam int unsigned PFDR_CTRL_PSE = 2; // large_page_flag
  localparam int unsigned PFDR_CTRL_PAE = 3; // physical_address_extension_flag
  localparam int unsigned PFDR_CTRL_NXE = 4; // execute-disable enabled
  localparam int unsigned PFDR_CTRL_W = 5;
  localparam logic [PFDR_CTRL_W-1:0] PFDR_CTRL_RST = 5'h00;

  // error code fields
  localparam int unsigned PFDR_EC_P = 0;
  localparam int unsigned PFDR_EC_WR = 1;
  localparam int unsigned PFDR_EC_US = 2;
  localparam int unsigned PFDR_EC_RESERVED_VIOLATION_BIT = 3;
  localparam int unsigned PFDR_EC_ID = 4;

  // reset value of the reported state and bytes per stack push
  localparam logic [31:0] PFDR_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] PFDR_PUSH_BYTES = 32'h0000_0004;

  // AXI4-Lite responses
  localparam logic [1:0] PFDR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFDR_RESP_SLVERR = 2'h2;

  // one translation step as reported by the page walker
  typedef struct packed {
    logic [31:0] linear_addr; // address being translated
    logic present;            // present flag of the entry used
    logic user_page;          // entry allows user access
    logic writable;           // entry allows writes
    logic exec_disable;       // execute-disable bit of the page
    logic reserved_violation_bit_set;           // a reserved directory bit holds 1
    logic is_write;           // access is a write
    logic is_fetch;           // access is an instruction fetch
    logic user_mode;          // code runs in user mode
  } pfdr_walk_s;

  // restart and delivery context from the core
  typedef struct packed {
    logic [31:0] cur_ip;      // instruction_pointer of faulting instr
    logic [31:0] new_task_ip; // first instruction of incoming task
    logic [31:0] cur_sp;      // stack_pointer in use now
    logic [31:0] handler_sp;  // stack of the handler's level or task
    logic in_task_switch;     // walk belongs to a task switch
    logic new_task_ctx;       // fault while reading new task tables
    logic handler_task;       // handler entered through a task gate
    logic handler_more_priv;  // handler runs more privileged
    logic sp_pending;         // stack segment loaded, pointer not yet
  } pfdr_ctx_s;

endpackage

// [rtl/pfdr_classify.sv]
/*
  pfdr_classify: combinational check of one translation step and
  assembly of the fault error code.
  Assumes the caller registers the results.
*/
`timescale 1ns/1ns

module pfdr_classify
  import pfdr_pkg::*;
(
  input wire pfdr_walk_s walk_in,            // translation step
  input wire logic [PFDR_CTRL_W-1:0] ctrl_in, // control bits
  output logic fault_out,                     // step must fault
  output logic [31:0] ecode_out               // error code word
);

  // ----------------------------------------------------------------------
  // fault causes
  // ----------------------------------------------------------------------
  wire pg = ctrl_in[PFDR_CTRL_PG];
  wire not_present = !walk_in.present;
  wire priv_viol = walk_in.user_mode && !walk_in.user_page;
  wire user_ro = walk_in.user_mode && walk_in.is_write
    && !walk_in.writable;
  // supervisor writes only trip on user pages, and only under wp
  wire sup_ro = !walk_in.user_mode && ctrl_in[PFDR_CTRL_WP]
    && walk_in.is_write && !walk_in.writable && walk_in.user_page;
  wire xd_on = ctrl_in[PFDR_CTRL_NXE];
  wire exec_viol = xd_on && walk_in.is_fetch && walk_in.exec_disable;
  wire reserved_violation_bit_viol = walk_in.reserved_violation_bit_set;
  wire large_or_ext = ctrl_in[PFDR_CTRL_PSE] || ctrl_in[PFDR_CTRL_PAE];

  // ----------------------------------------------------------------------
  // error code; absent pages dominate since their other bits mean nothing
  // ----------------------------------------------------------------------
  always_comb begin
    fault_out = pg && (not_present || priv_viol || user_ro || sup_ro
      || exec_viol || reserved_violation_bit_viol);
    ecode_out = PFDR_WORD_RST;
    ecode_out[PFDR_EC_P] = !not_present;
    ecode_out[PFDR_EC_WR] = walk_in.is_write;
    ecode_out[PFDR_EC_US] = walk_in.user_mode;
    ecode_out[PFDR_EC_RESERVED_VIOLATION_BIT] = !not_present && reserved_violation_bit_viol
      && large_or_ext;
    ecode_out[PFDR_EC_ID] = xd_on && walk_in.is_fetch;
  end

endmodule // pfdr_classify

// [verification/pfdr_handler_model.sv]
/*
  pfdr_handler_model: behavioural translation fault handler that stands
  on the far side of the fault unit and takes each delivered fault.
  Assumes fault_in pulses once per fault with the report outputs valid.
*/
`timescale 1ns/1ns

module pfdr_handler_model (
  input wire logic clk_in,               // core clock
  input wire logic rstn_in,              // sync reset, active low
  input wire logic fault_in,             // fault pulse from the unit
  input wire logic [31:0] fault_addr_in, // fault_address_register
  input wire logic [31:0] push_data_in,  // error code on the stack
  input wire logic [31:0] saved_ip_in,   // restart pointer
  output logic [31:0] saved_addr_out,    // handler's copy of the address
  output logic [31:0] frame_code_out,    // error code taken from frame
  output logic [31:0] resume_ip_out,     // where the return resumes
  output logic [7:0] entries_out         // handler entries seen
);
  // ---------------------------------------------------------------------
  // handler entry
  // ---------------------------------------------------------------------
  // the address is copied at entry: a later fault would overwrite it
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      saved_addr_out <= 32'h0000_0000;
      frame_code_out <= 32'h0000_0000;
      resume_ip_out <= 32'h0000_0000;
      entries_out <= 8'h00;
    end else if (fault_in) begin
      saved_addr_out <= fault_addr_in;
      frame_code_out <= push_data_in;
      resume_ip_out <= saved_ip_in;
      entries_out <= entries_out + 8'h01;
    end
  end
endmodule // pfdr_handler_model

// [verification/tb_page_fault_detect_report.sv]
/*
  tb_page_fault_detect_report: self-checking bench of the fault unit.
  Assumes the register map and walk timing of the package and notes.
*/
`timescale 1ns/1ns

module tb_page_fault_detect_report;
  import pfdr_pkg::*;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [7:0] w;
    logic f;
    logic [4:0] ec;
  } pfdr_row_s;
  // walk bits: present,user_page,writable,xd,reserved_violation_bit,write,fetch,user
  localparam pfdr_row_s ROWS [13] = '{
    '{5'h00, 8'h00, 1'b0, 5'h00}, '{5'h01, 8'h00, 1'b1, 5'h00},
    '{5'h01, 8'h05, 1'b1, 5'h06}, '{5'h01, 8'hA1, 1'b1, 5'h05},
    '{5'h01, 8'hC5, 1'b1, 5'h07}, '{5'h01, 8'hC4, 1'b0, 5'h00},
    '{5'h03, 8'hC4, 1'b1, 5'h03}, '{5'h11, 8'hF2, 1'b1, 5'h11},
    '{5'h01, 8'hF2, 1'b0, 5'h00}, '{5'h05, 8'hE8, 1'b1, 5'h09},
    '{5'h09, 8'hE8, 1'b1, 5'h09}, '{5'h01, 8'hE8, 1'b1, 5'h01},
    '{5'h01, 8'hE7, 1'b0, 5'h00}};
  logic clk_in = 1'b0, rstn_in = 1'b0, walk_valid_in = 1'b0;
  pfdr_walk_s walk_in = '0;
  pfdr_ctx_s ctx_in = '0, c0, c;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, fault_addr_out, push_data_out, push_addr_out;
  logic [31:0] saved_ip_out, rd, m_addr, m_code, m_ip;
  logic fault_out, own_stack_out, sp_inconsistent_out;
  logic load_full_state_out, accessed_set_out, write_block_out;
  logic [7:0] m_entries;
  int num_errors = 0, samples_checked = 0, cyc = 0, nf = 0;

  pfdr_fault_unit dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .walk_valid_in(walk_valid_in), .walk_in(walk_in), .ctx_in(ctx_in),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .fault_out(fault_out),
    .fault_addr_out(fault_addr_out), .push_data_out(push_data_out),
    .push_addr_out(push_addr_out), .saved_ip_out(saved_ip_out),
    .own_stack_out(own_stack_out),
    .sp_inconsistent_out(sp_inconsistent_out),
    .load_full_state_out(load_full_state_out),
    .accessed_set_out(accessed_set_out),
    .write_block_out(write_block_out));
  pfdr_handler_model partner (.clk_in(clk_in), .rstn_in(rstn_in),
    .fault_in(fault_out), .fault_addr_in(fault_addr_out),
    .push_data_in(push_data_out), .saved_ip_in(saved_ip_out),
    .saved_addr_out(m_addr), .frame_code_out(m_code),
    .resume_ip_out(m_ip), .entries_out(m_entries));

  // ---------------------------------------------------------------------
  // clock, timeout and reporting
  // ---------------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  // whole run is about 120 cycles; the ceiling leaves wide margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ---------------------------------------------------------------------
  // bus and walk drivers
  // ---------------------------------------------------------------------
  // each channel is released at the edge its own ready is seen
  task automatic axi_wr(logic [31:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(logic [31:0] a, logic [1:0] er);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // one step; returns just after the edge where the report lands
  task automatic walk(logic [31:0] a, logic [7:0] w, pfdr_ctx_s x);
    @(posedge clk_in);
    walk_in <= {a, w};
    ctx_in <= x;
    walk_valid_in <= 1'b1;
    @(posedge clk_in);
    walk_valid_in <= 1'b0;
    #1;
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    c0 = '0;
    c0.cur_ip = 32'h0040_1000;
    c0.new_task_ip = 32'h0080_2000;
    c0.cur_sp = 32'h0000_8000;
    c0.handler_sp = 32'h0001_0000;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("rst fault", fault_out, 0);
    chk("rst addr", fault_addr_out, PFDR_WORD_RST);
    chk("rst code", push_data_out, PFDR_WORD_RST);
    axi_rd({24'h0, PFDR_CTRL_OFS}, PFDR_RESP_OKAY);
    chk("ctrl rst", rd, {27'h0, PFDR_CTRL_RST});
    axi_rd(32'h0000_0100, PFDR_RESP_SLVERR);
    chk("unmapped", rd, 32'h0);
    axi_wr({24'h0, PFDR_ECODE_OFS}, 32'hFFFF_FFFF, PFDR_RESP_OKAY);
    axi_rd({24'h0, PFDR_ECODE_OFS}, PFDR_RESP_OKAY);
    chk("code ro", rd, 32'h0);
    axi_wr({24'h0, PFDR_FADDR_OFS}, 32'h1234_5678, PFDR_RESP_OKAY);
    axi_rd({24'h0, PFDR_FADDR_OFS}, PFDR_RESP_OKAY);
    chk("faddr rw", rd, 32'h1234_5678);
    $display("test registers done");
    for (int i = 0; i < 13; i++) begin
      axi_wr({24'h0, PFDR_CTRL_OFS}, {27'h0, ROWS[i].ctrl}, PFDR_RESP_OKAY);
      walk(32'h1000_0000 + (i << 12), ROWS[i].w, c0);
      chk("fault", fault_out, ROWS[i].f);
      if (ROWS[i].f) begin
        nf++;
        chk("code", push_data_out, ROWS[i].ec);
        chk("addr", fault_addr_out, 32'h1000_0000 + (i << 12));
        chk("accessed", accessed_set_out, ROWS[i].w[7]);
        chk("no full", load_full_state_out, 0);
        chk("wblock", write_block_out, ROWS[i].w[2]);
        chk("ip", saved_ip_out, c0.cur_ip);
        chk("push", push_addr_out, c0.cur_sp - PFDR_PUSH_BYTES);
      end
    end
    $display("test table done");
    c = c0;
    c.in_task_switch = 1'b1;
    c.new_task_ctx = 1'b1;
    walk(32'h2000_0000, 8'h00, c);
    chk("new ip", saved_ip_out, c0.new_task_ip);
    chk("full", load_full_state_out, 1);
    c = c0;
    c.sp_pending = 1'b1;
    walk(32'h2000_1000, 8'h00, c);
    chk("stale", sp_inconsistent_out, 1);
    chk("own", own_stack_out, 0);
    chk("push", push_addr_out, c0.cur_sp - PFDR_PUSH_BYTES);
    c.handler_more_priv = 1'b1;
    walk(32'h2000_2000, 8'h00, c);
    chk("stale", sp_inconsistent_out, 0);
    chk("own", own_stack_out, 1);
    chk("push", push_addr_out, c0.handler_sp - PFDR_PUSH_BYTES);
    $display("test context done");
    // back to back faults: the second address must win
    @(posedge clk_in);
    walk_in <= {32'h3000_0000, 8'h00};
    ctx_in <= c0;
    walk_valid_in <= 1'b1;
    @(posedge clk_in);
    walk_in <= {32'h3000_1000, 8'h00};
    #1;
    chk("fault1", fault_out, 1);
    chk("addr1", fault_addr_out, 32'h3000_0000);
    @(posedge clk_in);
    walk_valid_in <= 1'b0;
    #1;
    chk("fault2", fault_out, 1);
    chk("addr2", fault_addr_out, 32'h3000_1000);
    @(posedge clk_in);
    #1;
    chk("drop", fault_out, 0);
    nf = nf + 5;
    axi_rd({24'h0, PFDR_COUNT_OFS}, PFDR_RESP_OKAY);
    chk("count", rd, nf);
    chk("handler addr", m_addr, 32'h3000_1000);
    chk("handler code", m_code, 32'h0);
    chk("handler ip", m_ip, c0.cur_ip);
    chk("entries", {24'h0, m_entries}, nf);
    $display("test back to back done");
    // a reset in mid-run must clear the report and the control bits
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("rst2 fault", fault_out, 0);
    chk("rst2 addr", fault_addr_out, PFDR_WORD_RST);
    chk("rst2 push", push_addr_out, PFDR_WORD_RST);
    axi_rd({24'h0, PFDR_COUNT_OFS}, PFDR_RESP_OKAY);
    chk("rst2 count", rd, PFDR_WORD_RST);
    axi_rd({24'h0, PFDR_CTRL_OFS}, PFDR_RESP_OKAY);
    chk("rst2 ctrl", rd, {27'h0, PFDR_CTRL_RST});
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule // tb_page_fault_detect_report
